// file: lism_consts.vh
// Purpose: Constants for the linked interrupt status manager
// Assumes: APB byte addresses, 32-bit data
// Notes: Definitions only
`ifndef LISM_CONSTS_VH
`define LISM_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LISM_ADDR_W 12
`define LISM_OFS_FLAG_A 12'h000
`define LISM_OFS_FLAG_B 12'h004
`define LISM_OFS_EN_A 12'h008
`define LISM_OFS_EN_B 12'h00C
`define LISM_OFS_IDLE 12'h010
`define LISM_OFS_COND 12'h014
`define LISM_OFS_CURRENT_PEAK_WORD 12'h018
`define LISM_OFS_VOLTAGE_PEAK_WORD 12'h01C
`define LISM_OFS_SIGN 12'h020

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LISM_RST_WORD 32'h00000000
`define LISM_ZERO_WORD 32'h00000000
`define LISM_RST_BIT 1'b0
`define LISM_SET_BIT 1'b1

// ------------------------------------------------------------
// Linked flag positions
// ------------------------------------------------------------
`define LISM_BIT_RST_DONE 15
// Word b bits 0..2, no-load events
`define LISM_LINK_IDLE 32'h00000007
// Word b bits 16..18, sag, overcurrent, overvoltage
`define LISM_LINK_COND 32'h00070000
// Word b bit 23, current peak
`define LISM_LINK_CURRENT_PEAK_WORD 32'h00800000
// Word b bit 24, voltage peak
`define LISM_LINK_VOLTAGE_PEAK_WORD 32'h01000000
// Word a bits 6..8, 10..12, 9, 13, 18
`define LISM_LINK_SIGN 32'h00043FC0
// Word b bit 15, unmaskable
`define LISM_FORCE_B 32'h00008000

`endif

// file: lism_flag_bank.v
// Purpose: One 32-bit sticky event flag word with write-one-to-clear
// Assumes: Set and clear pulses from core_clk_i logic
// Notes: Set beats clear in the same cycle
`timescale 1ns/100ps
`include "lism_consts.vh"

module lism_flag_bank (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [31:0] set_i,
  input wire [31:0] clr_i,
  output wire [31:0] flags_o
);

  reg [31:0] flags_q;
  wire [31:0] flags_d;

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // Set wins so an event during a clear write is not lost
  assign flags_d = (flags_q & ~clr_i) | set_i;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= `LISM_RST_WORD;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule // lism_flag_bank

// file: lism_irq_manager.v
// Purpose: Event flags, enables, linked phase words and two interrupt outputs
// Assumes: Events and phase words come from core_clk_i logic; APB slave
// Notes: One wait state on every APB access; all outputs from flip-flops
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "lism_consts.vh"

module lism_irq_manager (
  input wire core_clk_i,
  input wire resetn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Event sources
  input wire [31:0] event_a_i,
  input wire [31:0] event_b_i,
  input wire [31:0] phase_idle_i,
  input wire [31:0] phase_condition_i,
  input wire [31:0] current_peak_i,
  input wire [31:0] voltage_peak_i,
  input wire [31:0] power_sign_i,
  // Interrupt pins
  output wire interrupt_out_a_n_o,
  output wire interrupt_out_b_n_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg [31:0] irq_enable_word_a_q;
  reg [31:0] irq_enable_word_b_q;
  reg [31:0] phase_idle_word_q;
  reg [31:0] phase_condition_word_q;
  reg [31:0] current_peak_word_q;
  reg [31:0] voltage_peak_word_q;
  reg [31:0] power_sign_word_q;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg pready_q;
  reg pslverr_q;
  reg pslverr_d;
  reg rst_pend_q;
  reg irq_a_n_q;
  reg irq_b_n_q;
  wire [31:0] flag_a;
  wire [31:0] flag_b;
  wire [31:0] set_a;
  wire [31:0] set_b;
  wire [31:0] clr_a;
  wire [31:0] clr_b;
  wire acc_start;
  wire acc_done;
  wire wr_done;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // True when any event in a linked group fires
  function link_hit;
    input [31:0] evt;
    input [31:0] grp;
    begin
      link_hit = |(evt & grp);
    end
  endfunction

  // Address decode, used for the error answer; read mux decodes the same offsets itself
  function addr_ok;
    input [11:0] addr;
    begin
      if (addr == `LISM_OFS_FLAG_A) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_FLAG_B) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_EN_A) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_EN_B) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_IDLE) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_COND) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_CURRENT_PEAK_WORD) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_VOLTAGE_PEAK_WORD) begin
        addr_ok = 1'b1;
      end else if (addr == `LISM_OFS_SIGN) begin
        addr_ok = 1'b1;
      end else begin
        addr_ok = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // APB handshake
  // ------------------------------------------------------------
  // One wait state so read data can come from a flop
  assign acc_start = psel_i & penable_i & ~pready_q;
  assign acc_done = psel_i & penable_i & pready_q;
  assign wr_done = acc_done & pwrite_i & ~pslverr_q;

  always @* begin
    prdata_d = `LISM_ZERO_WORD;
    pslverr_d = ~addr_ok(paddr_i);
    if (paddr_i == `LISM_OFS_FLAG_A) begin
      prdata_d = flag_a;
    end else if (paddr_i == `LISM_OFS_FLAG_B) begin
      prdata_d = flag_b;
    end else if (paddr_i == `LISM_OFS_EN_A) begin
      prdata_d = irq_enable_word_a_q;
    end else if (paddr_i == `LISM_OFS_EN_B) begin
      prdata_d = irq_enable_word_b_q;
    end else if (paddr_i == `LISM_OFS_IDLE) begin
      prdata_d = phase_idle_word_q;
    end else if (paddr_i == `LISM_OFS_COND) begin
      prdata_d = phase_condition_word_q;
    end else if (paddr_i == `LISM_OFS_CURRENT_PEAK_WORD) begin
      prdata_d = current_peak_word_q;
    end else if (paddr_i == `LISM_OFS_VOLTAGE_PEAK_WORD) begin
      prdata_d = voltage_peak_word_q;
    end else if (paddr_i == `LISM_OFS_SIGN) begin
      prdata_d = power_sign_word_q;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q <= `LISM_RST_BIT;
      pslverr_q <= `LISM_RST_BIT;
      prdata_q <= `LISM_RST_WORD;
    end else begin
      pready_q <= acc_start;
      if (acc_start) begin
        pslverr_q <= pslverr_d;
        // Write access reads back zero
        prdata_q <= pwrite_i ? `LISM_ZERO_WORD : prdata_d;
      end else begin
        pslverr_q <= `LISM_RST_BIT;
        prdata_q <= `LISM_RST_WORD;
      end
    end
  end

  // ------------------------------------------------------------
  // Enable words
  // ------------------------------------------------------------
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable_word_a_q <= `LISM_RST_WORD;
      irq_enable_word_b_q <= `LISM_RST_WORD;
    end else if (wr_done) begin
      if (paddr_i == `LISM_OFS_EN_A) begin
        irq_enable_word_a_q <= pwdata_i;
      end else if (paddr_i == `LISM_OFS_EN_B) begin
        irq_enable_word_b_q <= pwdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Linked per-phase words
  // ------------------------------------------------------------
  // Captured on the same edge the linked flag sets
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_idle_word_q <= `LISM_RST_WORD;
      phase_condition_word_q <= `LISM_RST_WORD;
      current_peak_word_q <= `LISM_RST_WORD;
      voltage_peak_word_q <= `LISM_RST_WORD;
      power_sign_word_q <= `LISM_RST_WORD;
    end else begin
      if (link_hit(event_b_i, `LISM_LINK_IDLE)) begin
        phase_idle_word_q <= phase_idle_i;
      end
      if (link_hit(event_b_i, `LISM_LINK_COND)) begin
        phase_condition_word_q <= phase_condition_i;
      end
      if (link_hit(event_b_i, `LISM_LINK_CURRENT_PEAK_WORD)) begin
        current_peak_word_q <= current_peak_i;
      end
      if (link_hit(event_b_i, `LISM_LINK_VOLTAGE_PEAK_WORD)) begin
        voltage_peak_word_q <= voltage_peak_i;
      end
      if (link_hit(event_a_i, `LISM_LINK_SIGN)) begin
        power_sign_word_q <= power_sign_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Flag words
  // ------------------------------------------------------------
  // Reset-done pulse on the first edge after release
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pend_q <= `LISM_SET_BIT;
    end else begin
      rst_pend_q <= `LISM_RST_BIT;
    end
  end

  assign set_a = event_a_i;
  assign set_b = event_b_i | (rst_pend_q ? `LISM_FORCE_B : `LISM_ZERO_WORD);
  // Ones written clear; zeros leave flags alone
  assign clr_a = (wr_done && paddr_i == `LISM_OFS_FLAG_A) ? pwdata_i : `LISM_ZERO_WORD;
  assign clr_b = (wr_done && paddr_i == `LISM_OFS_FLAG_B) ? pwdata_i : `LISM_ZERO_WORD;

  lism_flag_bank u_flag_a (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .set_i(set_a),
    .clr_i(clr_a),
    .flags_o(flag_a)
  );

  lism_flag_bank u_flag_b (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .set_i(set_b),
    .clr_i(clr_b),
    .flags_o(flag_b)
  );

  // ------------------------------------------------------------
  // Interrupt outputs
  // ------------------------------------------------------------
  // Registered, so pin follows flags one cycle later
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_a_n_q <= `LISM_SET_BIT;
      irq_b_n_q <= `LISM_SET_BIT;
    end else begin
      irq_a_n_q <= ~|(flag_a & irq_enable_word_a_q);
      // Reset-done ignores its enable bit
      irq_b_n_q <= ~|(flag_b & (irq_enable_word_b_q | `LISM_FORCE_B));
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign interrupt_out_a_n_o = irq_a_n_q;
  assign interrupt_out_b_n_o = irq_b_n_q;

endmodule // lism_irq_manager

// file: lism_irq_manager_properties.sv
// Purpose: Port-level properties of the interrupt flag manager
// Assumes: One clock domain, reset active low, one wait state per access
// Notes: Bound to every lism_irq_manager instance
`timescale 1ns/100ps
`include "lism_consts.vh"

module lism_irq_manager_properties (
  input wire core_clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire pready_o,
  input wire [31:0] event_a_i,
  input wire [31:0] event_b_i,
  input wire interrupt_out_a_n_o,
  input wire interrupt_out_b_n_o
);
  // ------------------------------------------------------------
  // Completed writes
  // ------------------------------------------------------------
  wire wr = psel_i && penable_i && pready_o && pwrite_i;
  wire wen_a = wr && (paddr_i == `LISM_OFS_EN_A);
  wire wen_b = wr && (paddr_i == `LISM_OFS_EN_B);
  wire wr_a = wen_a || (wr && (paddr_i == `LISM_OFS_FLAG_A));
  wire wr_b = wen_b || (wr && (paddr_i == `LISM_OFS_FLAG_B));

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_reset_finished_flag_low: assert property ($rose(resetn_i) |-> ##2 !interrupt_out_b_n_o)
    else $error("reset-done did not pull output b low");
  a_rise_b_cause: assert property ($rose(interrupt_out_b_n_o) |-> $past(wr_b, 2))
    else $error("output b released without a write");
  a_hold_b_low: assert property (!interrupt_out_b_n_o && !wr_b && !$past(wr_b)
    |=> !interrupt_out_b_n_o)
    else $error("output b released early");
  a_rise_a_cause: assert property ($rose(interrupt_out_a_n_o) |-> $past(wr_a, 2))
    else $error("output a released without a write");
  a_fall_a_cause: assert property ($fell(interrupt_out_a_n_o)
    |-> $past(event_a_i != 32'h00000000, 2) || $past(wen_a, 2))
    else $error("output a fell without event or enable");
  a_fall_b_cause: assert property ($fell(interrupt_out_b_n_o) |-> $past(wen_b, 2)
    || $past(event_b_i != 32'h00000000, 2) || !$past(resetn_i, 3))
    else $error("output b fell without cause");
endmodule // lism_irq_manager_properties

bind lism_irq_manager lism_irq_manager_properties i_props (
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pready_o(pready_o),
  .event_a_i(event_a_i),
  .event_b_i(event_b_i),
  .interrupt_out_a_n_o(interrupt_out_a_n_o),
  .interrupt_out_b_n_o(interrupt_out_b_n_o)
);

// file: lism_host.sv
// Purpose: Host model, APB master and interrupt service routine
// Assumes: Signals change only by non-blocking assignment after an edge
// Notes: Edge latch watches output b only
`timescale 1ns/100ps

module lism_host (
  input wire core_clk_i,
  input wire pready_i,
  input wire pslverr_i,
  input wire [31:0] prdata_i,
  input wire irq_b_n_i,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [11:0] paddr_o = 12'h000,
  output logic [31:0] pwdata_o = 32'h00000000
);
  logic irq_q = 1'b1;
  logic edge_q = 1'b0;

  // ------------------------------------------------------------
  // Falling-edge latch, cleared when service starts
  // ------------------------------------------------------------
  always @(posedge core_clk_i) begin
    irq_q <= irq_b_n_i;
    if (irq_q && !irq_b_n_i) begin
      edge_q <= 1'b1;
    end
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do @(posedge core_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // Flags, then linked word, then write back unchanged
  task automatic service(input logic [11:0] fa, input logic [11:0] wa,
                         output logic [31:0] fl, output logic [31:0] ph);
    logic [31:0] q;
    logic e;
    edge_q <= 1'b0;
    xfer(1'b0, fa, 32'h00000000, fl, e);
    xfer(1'b0, wa, 32'h00000000, ph, e);
    xfer(1'b1, fa, fl, q, e);
  endtask
endmodule // lism_host

// file: linked_interrupt_status_manager_test.sv
// Purpose: Self-checking bench of the interrupt flag manager
// Assumes: Host model drives the register bus
// Notes: Events are one-cycle pulses from the bench
`timescale 1ns/100ps
`include "lism_consts.vh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end

module linked_interrupt_status_manager_test;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [31:0] ev_a = 32'h00000000, ev_b = 32'h00000000, ph = 32'h00000000;
  logic [31:0] q, f, w;
  logic e;
  wire psel, penable, pwrite, pready, pslverr, irq_a_n, irq_b_n;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int fail_count = 0, n_compared = 0, cyc = 0;

  always #4 core_clk_i = ~core_clk_i;

  lism_irq_manager i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .event_a_i(ev_a),
    .event_b_i(ev_b), .phase_idle_i(ph), .phase_condition_i(ph ^ 32'h00000001),
    .current_peak_i(ph ^ 32'h00000002), .voltage_peak_i(ph ^ 32'h00000003),
    .power_sign_i(ph ^ 32'h00000004), .interrupt_out_a_n_o(irq_a_n),
    .interrupt_out_b_n_o(irq_b_n));
  lism_host i_host (.core_clk_i(core_clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .irq_b_n_i(irq_b_n), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    `CHK("irq_b", 1'b0, irq_b_n)
    `CHK("irq_a", 1'b1, irq_a_n)
    i_host.xfer(1'b0, `LISM_OFS_EN_B, 32'h00000000, q, e);
    `CHK("en_b", 32'h00000000, q)
    i_host.service(`LISM_OFS_FLAG_B, `LISM_OFS_COND, f, w);
    `CHK("flag_b", 32'h00008000, f)
    repeat (2) @(posedge core_clk_i);
    #1 `CHK("irq_b", 1'b1, irq_b_n)
  endtask

  // Event while masked, then enabling it pulls the pin
  task t_sign;
    @(posedge core_clk_i);
    ph <= 32'h5A0000F0;
    ev_a <= 32'h00040000;
    @(posedge core_clk_i);
    ph <= 32'h00000000;
    ev_a <= 32'h00000000;
    repeat (3) @(posedge core_clk_i);
    #1 `CHK("irq_a", 1'b1, irq_a_n)
    i_host.xfer(1'b1, `LISM_OFS_EN_A, 32'h00040000, q, e);
    repeat (2) @(posedge core_clk_i);
    #1 `CHK("irq_a", 1'b0, irq_a_n)
    i_host.service(`LISM_OFS_FLAG_A, `LISM_OFS_SIGN, f, w);
    `CHK("flag_a", 32'h00040000, f)
    `CHK("sign", 32'h5A0000F4, w)
    repeat (2) @(posedge core_clk_i);
    #1 `CHK("irq_a", 1'b1, irq_a_n)
  endtask

  task automatic t_linked;
    int bits [8] = '{0, 1, 2, 16, 17, 18, 23, 24};
    logic [11:0] adr [8] = '{`LISM_OFS_IDLE, `LISM_OFS_IDLE, `LISM_OFS_IDLE, `LISM_OFS_COND,
      `LISM_OFS_COND, `LISM_OFS_COND, `LISM_OFS_CURRENT_PEAK_WORD, `LISM_OFS_VOLTAGE_PEAK_WORD};
    logic [31:0] v;
    i_host.xfer(1'b1, `LISM_OFS_EN_B, 32'hFFFFFFFF, q, e);
    foreach (bits[i]) begin
      v = 32'hA5000000 | (i << 8);
      @(posedge core_clk_i);
      ph <= v;
      ev_b <= 32'h00000001 << bits[i];
      @(posedge core_clk_i);
      ph <= ~v;
      ev_b <= 32'h00000000;
      repeat (2) @(posedge core_clk_i);
      #1 `CHK("irq_b", 1'b0, irq_b_n)
      `CHK("edge", 1'b1, i_host.edge_q)
      i_host.service(`LISM_OFS_FLAG_B, adr[i], f, w);
      `CHK("flag_b", 32'h00000001 << bits[i], f)
      `CHK("phase", v ^ {20'h00000, (adr[i] - 12'h010) >> 2}, w)
      repeat (2) @(posedge core_clk_i);
      #1 `CHK("irq_b", 1'b1, irq_b_n)
    end
  endtask

  // Event just after the clearing write: pin pulses high, host must re-enter
  task t_reentry;
    @(posedge core_clk_i);
    ev_b <= 32'h00020000;
    @(posedge core_clk_i);
    ev_b <= 32'h00000000;
    repeat (3) @(posedge core_clk_i);
    #1 `CHK("edge", 1'b1, i_host.edge_q)
    i_host.service(`LISM_OFS_FLAG_B, `LISM_OFS_COND, f, w);
    `CHK("flag_b", 32'h00020000, f)
    ev_b <= 32'h00010000;
    @(posedge core_clk_i);
    ev_b <= 32'h00000000;
    repeat (3) @(posedge core_clk_i);
    #1 `CHK("edge", 1'b1, i_host.edge_q)
    `CHK("irq_b", 1'b0, irq_b_n)
    i_host.service(`LISM_OFS_FLAG_B, `LISM_OFS_COND, f, w);
    `CHK("flag_b", 32'h00010000, f)
    `CHK("phase", ph ^ 32'h00000001, w)
    repeat (2) @(posedge core_clk_i);
    #1 `CHK("irq_b", 1'b1, irq_b_n)
  endtask

  task t_unmapped;
    i_host.xfer(1'b0, 12'h024, 32'h00000000, q, e);
    `CHK("err", 1'b1, e)
    `CHK("rdata", 32'h00000000, q)
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim;
    end
  end

  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 t_reset;
    t_sign;
    t_linked;
    t_reentry;
    t_unmapped;
    end_sim;
  end
endmodule // linked_interrupt_status_manager_test
